// ===== hdl/pfs_pin_sync.sv
// Purpose: three-stage synchroniser for port pin levels
// Assumes: pins are asynchronous to ref_clk
// Notes: a level change is taken once stages two and three agree
`timescale 1ns/1ns
module pfs_pin_sync #(
	parameter int W = 22
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] level_o
);
	import pfs_pkg::*;

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} pfs_sync_st_t;

	pfs_sync_st_t st_r;
	pfs_sync_st_t st_nxt;
	logic [W-1:0] lvl_nxt;

	// per-bit agreement filter; stage one feeds only stage two
	generate
		for (genvar i = 0; i < W; i++) begin : g_bit
			assign lvl_nxt[i] = (st_r.s2[i] == st_r.s3[i]) ? st_r.s3[i] : st_r.lvl[i];
		end
	endgenerate

	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin_i;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.lvl = lvl_nxt;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign level_o = st_r.lvl;
endmodule : pfs_pin_sync

// ===== hdl/pfs_pkg.sv
// Purpose: shared constants and carriers for the port A pin function select block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: pins 8..29 of the port are handled, pins 8..13 are multiplexed
package pfs_pkg;
	localparam int PFS_AW = 8;
	localparam int PFS_NPIN = 22;
	localparam int PFS_NMUX = 6;
	localparam int PFS_SYNC_STAGES = 3;
	// register byte offsets
	localparam logic [PFS_AW-1:0] PFS_OFS_CTL_LO = 8'h00;
	localparam logic [PFS_AW-1:0] PFS_OFS_CTL_HI = 8'h04;
	localparam logic [PFS_AW-1:0] PFS_OFS_DAT_HI = 8'h08;
	localparam logic [PFS_AW-1:0] PFS_OFS_DAT_LO = 8'h0c;
	localparam logic [PFS_AW-1:0] PFS_OFS_DIR = 8'h10;
	// reset values
	localparam logic [11:0] PFS_RST_CTL_LO = 12'h000;
	localparam logic [5:0] PFS_RST_CTL_HI = 6'h00;
	localparam logic [13:0] PFS_RST_DAT_HI = 14'h0000;
	localparam logic [7:0] PFS_RST_DAT_LO = 8'h00;
	localparam logic [21:0] PFS_RST_DIR = 22'h000000;
	// mode field codes and bit positions of fields
	localparam logic [2:0] PFS_MD_PORT = 3'h0;
	localparam logic [2:0] PFS_MD_BUS = 3'h1;
	localparam logic [2:0] PFS_MD_IN2 = 3'h2;
	localparam logic [2:0] PFS_MD_IN3 = 3'h3;
	localparam int PFS_FLD_W = 3;
	localparam int PFS_FLD_STRIDE = 4;
	// mode fields whose lsb resets to one in external mode with program memory off
	localparam logic [11:0] PFS_EXT_CTL_LO = 12'h240;
	localparam logic [5:0] PFS_EXT_CTL_HI = 6'h09;
	localparam logic [1:0] PFS_RESP_OKAY = 2'h0;
	localparam logic [1:0] PFS_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic awvalid;
		logic [PFS_AW-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [PFS_AW-1:0] araddr;
		logic rready;
	} pfs_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pfs_axi_rsp_t;

	typedef enum logic [1:0] {
		PFS_ST_INIT = 2'b01,
		PFS_ST_RUN = 2'b10
	} pfs_state_t;
endpackage : pfs_pkg

// ===== hdl/pfs_top.sv
// Purpose: port A pin function select and port data logic, AXI4-Lite registers
// Assumes: one clock ref_clk at 10 MHz, pins 8..29 of the port
// Notes: pins 8..13 are multiplexed, pins 14..29 are plain port pins
// Function
// R1 - pin 13 field: 000 port, 001 upper write strobe/mask out, 011 disable request in
// R2 - pin 12 field: 000 port, 001 lower write strobe/mask out, 011 disable request in
// R3 - reserved bits of mode control registers always read back as zero
// R4 - software writes zero into all reserved bit positions
// R5 - selected mode field lsbs reset to one in external mode, program memory off
// R6 - software never selects bus output functions while in single-chip mode
// R7 - pins 11..8 fields at 14:12, 10:8, 6:4, 2:0; bits 15,11,7,3 read-only
// R8 - upper data register: pins 16..29 at bits 13:0, reset 0, bits 15:14 read 0
// R9 - port mode drives or samples the data bit; other modes ignore it
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module pfs_top (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic boot_ext_rom_off,
	input wire pfs_pkg::pfs_axi_req_t axi_req,
	output pfs_pkg::pfs_axi_rsp_t axi_rsp,
	input wire logic [pfs_pkg::PFS_NPIN-1:0] pin_i,
	output logic [pfs_pkg::PFS_NPIN-1:0] pin_o,
	output logic [pfs_pkg::PFS_NPIN-1:0] pin_oe,
	input wire logic [pfs_pkg::PFS_NMUX-1:0] bus_fn_out,
	output logic [pfs_pkg::PFS_NMUX-1:0] periph_in_n
);
	import pfs_pkg::*;

	typedef struct packed {
		pfs_state_t state;
		logic [11:0] ctl_lo;
		logic [5:0] ctl_hi;
		logic [13:0] dat_hi;
		logic [7:0] dat_lo;
		logic [21:0] dir;
		pfs_axi_rsp_t rsp;
		logic [PFS_NPIN-1:0] po;
		logic [PFS_NPIN-1:0] port_output_enable_unit;
		logic [PFS_NMUX-1:0] pin_n;
	} pfs_top_st_t;

	pfs_top_st_t st_r;
	pfs_top_st_t st_nxt;
	logic [1:0] rst_sync_r;
	logic rst_n_int;
	logic [PFS_NPIN-1:0] pin_lvl;
	logic [2:0] mode [PFS_NMUX];

	////////////////////////////////////////////////////////////////////////////////
	// reset release and pin synchronisers

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_r <= 2'h0;
		end else if (ce) begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n_int = rst_sync_r[1];

	pfs_pin_sync #(
		.W(PFS_NPIN)
	) u_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n_int),
		.ce(ce),
		.pin_i(pin_i),
		.level_o(pin_lvl)
	);

	////////////////////////////////////////////////////////////////////////////////
	// mode field per multiplexed pin

	generate
		for (genvar i = 0; i < PFS_NMUX; i++) begin : g_mode
			if (i < 4) begin : g_lo
				assign mode[i] = st_r.ctl_lo[i*PFS_FLD_W +: PFS_FLD_W]; // R7
			end else begin : g_hi
				assign mode[i] = st_r.ctl_hi[(i-4)*PFS_FLD_W +: PFS_FLD_W]; // R1 R2
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (wd & m);
	endfunction : merge

	// fields of 3 bits packed at a 4-bit stride; the gap bits read as zero
	function automatic logic [15:0] spread(input logic [11:0] f);
		logic [15:0] v;
		v = 16'h0000;
		for (int k = 0; k < 4; k++) begin
			v[k*PFS_FLD_STRIDE +: PFS_FLD_W] = f[k*PFS_FLD_W +: PFS_FLD_W];
		end
		return v;
	endfunction : spread

	function automatic logic [11:0] pack(input logic [15:0] v);
		logic [11:0] f;
		f = 12'h000;
		for (int k = 0; k < 4; k++) begin
			f[k*PFS_FLD_W +: PFS_FLD_W] = v[k*PFS_FLD_STRIDE +: PFS_FLD_W];
		end
		return f;
	endfunction : pack

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [PFS_NPIN-1:0] dat;
		logic [PFS_NPIN-1:0] port_rd;
		logic [31:0] wv;
		logic [31:0] rv;
		logic hit;
		logic [11:0] pk;
		st_nxt = st_r;
		dat = {st_r.dat_hi, st_r.dat_lo};
		// input pins read their level, output pins their latched bit
		port_rd = (dat & st_r.dir) | (pin_lvl & ~st_r.dir); // R9
		wv = 32'h00000000;
		rv = 32'h00000000;
		hit = 1'b0;
		pk = 12'h000;

		case (st_r.state)
			PFS_ST_INIT: begin
				// strap is caught on the first enabled edge after release
				if (boot_ext_rom_off) begin
					st_nxt.ctl_lo = PFS_RST_CTL_LO | PFS_EXT_CTL_LO; // R5
					st_nxt.ctl_hi = PFS_RST_CTL_HI | PFS_EXT_CTL_HI; // R5
				end
				st_nxt.state = PFS_ST_RUN;
			end
			PFS_ST_RUN: begin
				// write: both channels taken together, one edge after both are valid
				st_nxt.rsp.awready = 1'b0;
				st_nxt.rsp.wready = 1'b0;
				if (axi_req.awvalid && axi_req.wvalid && !st_r.rsp.awready &&
						!st_r.rsp.bvalid) begin
					st_nxt.rsp.awready = 1'b1;
					st_nxt.rsp.wready = 1'b1;
				end
				if (st_r.rsp.awready) begin
					hit = 1'b1;
					case (axi_req.awaddr)
						PFS_OFS_CTL_LO: begin
							wv = merge({16'h0000, spread(st_r.ctl_lo)}, axi_req.wdata,
								axi_req.wstrb);
							st_nxt.ctl_lo = pack(wv[15:0]); // R7 R3
						end
						PFS_OFS_CTL_HI: begin
							wv = merge({16'h0000, spread({6'h00, st_r.ctl_hi})},
								axi_req.wdata, axi_req.wstrb);
							pk = pack(wv[15:0]);
							st_nxt.ctl_hi = pk[5:0]; // R1 R2 R3
						end
						PFS_OFS_DAT_HI: begin
							wv = merge({18'h00000, st_r.dat_hi}, axi_req.wdata, axi_req.wstrb);
							st_nxt.dat_hi = wv[13:0]; // R8
						end
						PFS_OFS_DAT_LO: begin
							wv = merge({24'h000000, st_r.dat_lo}, axi_req.wdata, axi_req.wstrb);
							st_nxt.dat_lo = wv[7:0];
						end
						PFS_OFS_DIR: begin
							wv = merge({10'h000, st_r.dir}, axi_req.wdata, axi_req.wstrb);
							st_nxt.dir = wv[21:0];
						end
						default: hit = 1'b0;
					endcase
					st_nxt.rsp.bvalid = 1'b1;
					st_nxt.rsp.bresp = hit ? PFS_RESP_OKAY : PFS_RESP_SLVERR;
				end else if (st_r.rsp.bvalid && axi_req.bready) begin
					st_nxt.rsp.bvalid = 1'b0;
				end

				// read
				st_nxt.rsp.arready = 1'b0;
				if (axi_req.arvalid && !st_r.rsp.arready && !st_r.rsp.rvalid) begin
					st_nxt.rsp.arready = 1'b1;
				end
				if (st_r.rsp.arready) begin
					hit = 1'b1;
					case (axi_req.araddr)
						PFS_OFS_CTL_LO: rv = {16'h0000, spread(st_r.ctl_lo)}; // R3 R7
						PFS_OFS_CTL_HI: rv = {16'h0000, spread({6'h00, st_r.ctl_hi})}; // R3
						PFS_OFS_DAT_HI: rv = {18'h00000, port_rd[21:8]}; // R8
						PFS_OFS_DAT_LO: rv = {24'h000000, port_rd[7:0]};
						PFS_OFS_DIR: rv = {10'h000, st_r.dir};
						default: hit = 1'b0;
					endcase
					st_nxt.rsp.rvalid = 1'b1;
					st_nxt.rsp.rdata = rv;
					st_nxt.rsp.rresp = hit ? PFS_RESP_OKAY : PFS_RESP_SLVERR;
				end else if (st_r.rsp.rvalid && axi_req.rready) begin
					st_nxt.rsp.rvalid = 1'b0;
				end
			end
			default: st_nxt.state = PFS_ST_INIT;
		endcase

		// pin routing; prohibited codes leave the pin undriven as a safe default
		for (int k = 0; k < PFS_NPIN; k++) begin
			st_nxt.po[k] = dat[k]; // R9
			st_nxt.port_output_enable_unit[k] = st_r.dir[k]; // R9
		end
		for (int k = 0; k < PFS_NMUX; k++) begin
			st_nxt.pin_n[k] = 1'b1;
			case (mode[k])
				PFS_MD_PORT: begin
				end
				PFS_MD_BUS: begin
					st_nxt.po[k] = bus_fn_out[k]; // R1 R2
					st_nxt.port_output_enable_unit[k] = 1'b1; // R1 R2
				end
				PFS_MD_IN2, PFS_MD_IN3: begin
					st_nxt.po[k] = 1'b0;
					st_nxt.port_output_enable_unit[k] = 1'b0;
					st_nxt.pin_n[k] = pin_lvl[k]; // R1 R2
				end
				default: begin
					st_nxt.po[k] = 1'b0;
					st_nxt.port_output_enable_unit[k] = 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge ref_clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			st_r <= '0;
			st_r.state <= PFS_ST_INIT;
			st_r.ctl_lo <= PFS_RST_CTL_LO;
			st_r.ctl_hi <= PFS_RST_CTL_HI;
			st_r.dat_hi <= PFS_RST_DAT_HI; // R8
			st_r.dat_lo <= PFS_RST_DAT_LO;
			st_r.dir <= PFS_RST_DIR;
			st_r.pin_n <= '1;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign axi_rsp = st_r.rsp;
	assign pin_o = st_r.po;
	assign pin_oe = st_r.port_output_enable_unit;
	assign periph_in_n = st_r.pin_n;
endmodule : pfs_top

// ===== tb/pfs_assertions.sv
// Purpose: port checks for pfs_top
// Assumes: ce held high
// Notes: pin 12 and pin 13 mode fields mirrored from bus writes
`timescale 1ns/1ns
module pfs_assertions (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire pfs_pkg::pfs_axi_req_t axi_req,
	input wire pfs_pkg::pfs_axi_rsp_t axi_rsp,
	input wire logic [pfs_pkg::PFS_NPIN-1:0] pin_o,
	input wire logic [pfs_pkg::PFS_NPIN-1:0] pin_oe,
	input wire logic [pfs_pkg::PFS_NMUX-1:0] bus_fn_out,
	input wire logic [pfs_pkg::PFS_NMUX-1:0] periph_in_n
);
	import pfs_pkg::*;
	typedef struct packed {
		logic f;
		logic [2:0] m12;
		logic [2:0] m13;
		logic [7:0] ra;
	} pfs_chk_t;
	pfs_chk_t s_r;
	pfs_chk_t s_nxt;
	logic rv;
	logic [31:0] rd;
	assign rv = axi_rsp.rvalid;
	assign rd = axi_rsp.rdata;
	always_comb begin
		s_nxt = s_r;
		if (axi_req.awvalid && axi_rsp.awready && axi_req.awaddr == PFS_OFS_CTL_HI) begin
			s_nxt.f = 1'b1;
			s_nxt.m12 = axi_req.wdata[2:0];
			s_nxt.m13 = axi_req.wdata[6:4];
		end
		if (axi_req.arvalid && axi_rsp.arready) begin
			s_nxt.ra = axi_req.araddr;
		end
	end
	// flag stays low until a write to PFS_OFS_CTL_HI, strap reset values are not mirrored
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////
	property p_m13_bus;
		s_r.f && s_r.m13 == 3'h1 |=> pin_oe[5] && pin_o[5] == $past(bus_fn_out[5]);
	endproperty
	a_m13_bus: assert property (p_m13_bus) else $error("pin13 bus");
	property p_m13_in;
		s_r.f && s_r.m13 == 3'h3 |=> !pin_oe[5];
	endproperty
	a_m13_in: assert property (p_m13_in) else $error("pin13 in");
	property p_m13_port;
		s_r.f && s_r.m13 == 3'h0 |=> periph_in_n[5];
	endproperty
	a_m13_port: assert property (p_m13_port) else $error("pin13 port");
	property p_m12_bus;
		s_r.f && s_r.m12 == 3'h1 |=> pin_oe[4] && pin_o[4] == $past(bus_fn_out[4]);
	endproperty
	a_m12_bus: assert property (p_m12_bus) else $error("pin12 bus");
	property p_m12_in;
		s_r.f && s_r.m12 == 3'h3 |=> !pin_oe[4];
	endproperty
	a_m12_in: assert property (p_m12_in) else $error("pin12 in");
	property p_lo_rsvd;
		rv && s_r.ra == 8'h00 |-> rd[31:16] == 16'h0 && {rd[15], rd[11], rd[7], rd[3]} == 4'h0;
	endproperty
	a_lo_rsvd: assert property (p_lo_rsvd) else $error("ctl lo reserved");
	property p_hi_rsvd;
		rv && s_r.ra == 8'h04 |-> rd[31:7] == 25'h0 && !rd[3];
	endproperty
	a_hi_rsvd: assert property (p_hi_rsvd) else $error("ctl hi reserved");
	property p_dat_rsvd;
		rv && s_r.ra == 8'h08 |-> rd[31:14] == 18'h0;
	endproperty
	a_dat_rsvd: assert property (p_dat_rsvd) else $error("data reserved");
	cover property (s_r.f && s_r.m12 == 3'h1);
	cover property (rv && s_r.ra == 8'h08);
	cover property (axi_rsp.bvalid && axi_rsp.bresp == 2'h2);
endmodule : pfs_assertions
bind pfs_top pfs_assertions u_pfs_assertions (.ref_clk(ref_clk), .rst_n(rst_n),
	.axi_req(axi_req), .axi_rsp(axi_rsp), .pin_o(pin_o), .pin_oe(pin_oe),
	.bus_fn_out(bus_fn_out), .periph_in_n(periph_in_n));

// ===== tb/tb.sv
// Purpose: self-checking bench for pfs_top
// Assumes: ce high except in the freeze scenario, full write strobes
// Notes: reserved bits always written as zero
`timescale 1ns/1ns
module tb;
	import pfs_pkg::*;
	logic ref_clk;
	logic rst_n;
	logic ce;
	logic boot_ext_rom_off;
	pfs_axi_req_t req;
	pfs_axi_rsp_t rsp;
	logic [21:0] pin_i;
	logic [21:0] pin_o;
	logic [21:0] pin_oe;
	logic [5:0] bus_fn_out;
	logic [5:0] periph_in_n;
	int errors;
	int check_count;
	int cyc;
	pfs_top u_pfs_top (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
		.boot_ext_rom_off(boot_ext_rom_off), .axi_req(req), .axi_rsp(rsp), .pin_i(pin_i),
		.pin_o(pin_o), .pin_oe(pin_oe), .bus_fn_out(bus_fn_out), .periph_in_n(periph_in_n));
	initial begin
		ref_clk = 1'b0;
		forever begin
			#50 ref_clk = ~ref_clk;
		end
	end
	task automatic finish_test;
		if (errors == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : wt
	task automatic rst(input logic strap);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		boot_ext_rom_off <= strap;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge ref_clk);
	endtask : rst
	////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge ref_clk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (rsp.awready) begin
				req.awvalid <= 1'b0;
			end
			if (rsp.wready) begin
				req.wvalid <= 1'b0;
			end
		end while (rsp.bvalid !== 1'b1);
		chk(32'(rsp.bresp), 32'(e));
		req.bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge ref_clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (rsp.arready) begin
				req.arvalid <= 1'b0;
			end
		end while (rsp.rvalid !== 1'b1);
		chk(rsp.rdata, d);
		chk(32'(rsp.rresp), 32'(e));
		req.rready <= 1'b0;
	endtask : rd
	////////////////////////////////////////////////////////////////
	task automatic t_strap;
		rd(8'h00, 32'h1100, 2'h0);
		rd(8'h04, 32'h11, 2'h0);
	endtask : t_strap
	task automatic t_fields;
		wr(8'h00, 32'h3103, 2'h0);
		rd(8'h00, 32'h3103, 2'h0);
		wr(8'h00, 32'h0131, 2'h0);
		rd(8'h00, 32'h0131, 2'h0);
	endtask : t_fields
	task automatic t_data;
		pin_i <= {14'h2a5c, 8'h00};
		wt(8);
		rd(8'h08, 32'h2a5c, 2'h0);
		wr(8'h10, 32'h3fff00, 2'h0);
		wr(8'h08, 32'h3fff, 2'h0);
		rd(8'h08, 32'h3fff, 2'h0);
		wr(8'h08, 32'h1555, 2'h0);
		wt(2);
		chk(32'(pin_o[21:8]), 32'h1555);
		chk(32'(pin_oe[21:8]), 32'h3fff);
	endtask : t_data
	task automatic t_mux;
		wr(8'h10, 32'h3fff30, 2'h0);
		wr(8'h0c, 32'h30, 2'h0);
		wr(8'h04, 32'h0, 2'h0);
		wt(2);
		chk(32'({pin_oe[5:4], pin_o[5:4], periph_in_n[5:4]}), 32'h3f);
		bus_fn_out <= 6'h10;
		wr(8'h04, 32'h11, 2'h0);
		wt(2);
		chk(32'({pin_oe[5:4], pin_o[5:4]}), 32'hd);
		bus_fn_out <= 6'h20;
		wt(2);
		chk(32'(pin_o[5:4]), 32'h2);
		pin_i <= {14'h2a5c, 8'h10};
		wr(8'h04, 32'h33, 2'h0);
		wt(8);
		chk(32'({pin_oe[5:4], periph_in_n[5:4]}), 32'h1);
	endtask : t_mux
	task automatic t_freeze;
		// fields are still input mode here; a frozen block must not pass the new levels on
		ce <= 1'b0;
		pin_i <= {14'h2a5c, 8'h20};
		wt(8);
		chk(32'(periph_in_n[5:4]), 32'h1);
		ce <= 1'b1;
		wt(8);
		chk(32'(periph_in_n[5:4]), 32'h2);
	endtask : t_freeze
	task automatic t_bad;
		wr(8'h20, 32'h0, 2'h2);
		rd(8'h20, 32'h0, 2'h2);
		rd(8'h04, 32'h33, 2'h0);
	endtask : t_bad
	task automatic t_reset;
		pin_i <= '0;
		rst(1'b0);
		rd(8'h00, 32'h0, 2'h0);
		rd(8'h04, 32'h0, 2'h0);
		rd(8'h08, 32'h0, 2'h0);
	endtask : t_reset
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		boot_ext_rom_off = 1'b1;
		req = '0;
		req.wstrb = 4'hf;
		pin_i = '0;
		bus_fn_out = '0;
		rst(1'b1);
		t_strap();
		t_fields();
		t_data();
		t_mux();
		t_freeze();
		t_bad();
		t_reset();
		finish_test();
	end
endmodule : tb
